/* inc/tmr_pkg.sv */
// constants for the 8-bit timer/counter with shared prescaler
// assumes one instruction-cycle clock and a simple strobe register port
package tmr_pkg;
  localparam logic [1:0] ADDR_COUNT = 2'h0;
  localparam logic [1:0] ADDR_OPTION = 2'h1;
  localparam logic [1:0] ADDR_CMP = 2'h2;
  localparam logic [1:0] ADDR_STATUS = 2'h3;
  localparam int OPT_SRC_BIT = 5;
  localparam int OPT_EDGE_BIT = 4;
  localparam int OPT_PSA_BIT = 3;
  localparam int OPT_PS_MSB = 2;
  localparam int CMP_OUTEN_BIT = 6;
  localparam int CMP_CSEL_BIT = 3;
  localparam logic [5:0] OPTION_RESET = 6'h3F;
  localparam logic [7:0] CMP_RESET = 8'h48;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] PRESC_RESET = 8'h00;
  localparam logic [1:0] INHIBIT_CYCLES = 2'h2;
endpackage

/* src/timer_counter.sv */
// timer/counter with 8-bit prescaler shared with the watchdog
// assumes pin and comparator inputs are async and bus is on ref_clk_i
//
// Operation
// [R1] timer mode when source select is zero
// [R2] timer without prescaler counts every cycle
// [R3] write to count inhibits two increments
// [R4] pin source when all three selects set
// [R5] pin mode counts one chosen edge
// [R6] edge select zero rising, one falling
// [R7] comparator source when comparator select clear
// [R8] output enable ignored in comparator mode
// [R9] prescaler serves timer or watchdog, never both
// [R10] assignment bit zero timer, one watchdog
// [R11] prescaler count never visible to software
// [R12] timer ratios two through 256
// [R13] count and prescaler are 8 bits
// [R14] count write and reset clear prescaler; count write clears it only while assigned to timer
// [R15] option bits: source5 edge4 assign3 ratio2..0
// [R16] pin synchronised before counting
// [R17] ratio code n divides by two^(n+1)
// [R18] count wraps; prescaler output drives when assigned
`timescale 1ns/1ps
module timer_counter (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic external_count_pin_i,
  input wire logic comparator_out_i,
  input wire logic watchdog_tick_i,
  input wire logic watchdog_clear_i,
  output logic watchdog_timeout_o
);
  typedef enum logic [2:0] {
    SRC_TIMER = 3'h1,
    SRC_PIN = 3'h2,
    SRC_CMP = 3'h4
  } src_t;

  logic [7:0] count, next_count;
  logic [7:0] presc, next_presc;
  logic [5:0] option, next_option;
  logic [7:0] cmp_ctl, next_cmp_ctl;
  logic [1:0] inhibit, next_inhibit;
  logic [7:0] next_rdata;
  logic pin_s1, pin_s2, pin_s3;
  logic cmp_s1, cmp_s2, cmp_s3;
  logic wdt_out, next_wdt_out;
  src_t src;
  logic src_event, presc_to_timer, tick, presc_out;
  logic write_count;

  // tap bit of an 8-bit ripple-style prescaler for a ratio code
  function automatic logic tap_fall(input logic [7:0] cur,
                                    input logic [7:0] nxt,
                                    input logic [2:0] code);
    tap_fall = cur[code] & ~nxt[code]; // [R17]
  endfunction

  assign write_count = wr_i && addr_i == tmr_pkg::ADDR_COUNT;
  assign presc_to_timer = ~option[tmr_pkg::OPT_PSA_BIT]; // [R10]

  always_comb begin
    if (!option[tmr_pkg::OPT_SRC_BIT]) begin
      src = SRC_TIMER; // [R1]
    end else if (!cmp_ctl[tmr_pkg::CMP_CSEL_BIT]) begin
      src = SRC_CMP; // [R7] [R8]
    end else begin
      // outen clear with pin select leaves no source
      src = cmp_ctl[tmr_pkg::CMP_OUTEN_BIT] ? SRC_PIN : SRC_TIMER; // [R4]
    end
  end

  always_comb begin
    case (src)
      SRC_TIMER: src_event = option[tmr_pkg::OPT_SRC_BIT] ? 1'b0 : 1'b1;
      SRC_PIN: src_event = option[tmr_pkg::OPT_EDGE_BIT] ?
                           (pin_s3 & ~pin_s2) : (~pin_s3 & pin_s2); // [R5] [R6]
      SRC_CMP: src_event = ~cmp_s3 & cmp_s2;
      default: src_event = 1'b0;
    endcase
  end

  always_comb begin
    next_presc = presc;
    presc_out = 1'b0;
    next_wdt_out = 1'b0;
    if (presc_to_timer) begin
      if (write_count) begin
        next_presc = tmr_pkg::PRESC_RESET; // [R14]
      end else if (src_event) begin
        next_presc = presc + 8'h01; // [R13]
        presc_out = tap_fall(presc, next_presc,
                             option[tmr_pkg::OPT_PS_MSB:0]); // [R12]
      end
    end else begin
      // watchdog owns the prescaler; timer sees none [R9]
      if (watchdog_clear_i) begin
        next_presc = tmr_pkg::PRESC_RESET;
      end else if (watchdog_tick_i) begin
        next_presc = presc + 8'h01;
        next_wdt_out = tap_fall(presc, next_presc,
                                option[tmr_pkg::OPT_PS_MSB:0]);
      end
    end
  end

  assign tick = presc_to_timer ? presc_out : src_event; // [R18] [R2]

  always_comb begin
    next_count = count;
    next_inhibit = inhibit;
    next_option = option;
    next_cmp_ctl = cmp_ctl;
    if (write_count) begin
      next_count = wdata_i;
      next_inhibit = tmr_pkg::INHIBIT_CYCLES; // [R3]
    end else if (inhibit != 2'h0) begin
      next_inhibit = inhibit - 2'h1; // [R3]
    end else if (tick) begin
      next_count = count + 8'h01; // [R18]
    end
    if (wr_i && addr_i == tmr_pkg::ADDR_OPTION) begin
      next_option = wdata_i[5:0]; // [R15]
    end
    if (wr_i && addr_i == tmr_pkg::ADDR_CMP) begin
      next_cmp_ctl = wdata_i;
    end
  end

  // prescaler is deliberately absent from the read map
  always_comb begin
    next_rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        tmr_pkg::ADDR_COUNT: next_rdata = count;
        tmr_pkg::ADDR_OPTION: next_rdata = {2'h0, option};
        tmr_pkg::ADDR_CMP: next_rdata = cmp_ctl;
        tmr_pkg::ADDR_STATUS: next_rdata = {5'h00, inhibit, presc_to_timer};
        default: next_rdata = 8'h00;
      endcase
    end
  end // [R11]

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
      cmp_s3 <= 1'b0;
    end else if (clk_en_i) begin
      pin_s1 <= external_count_pin_i; // [R16]
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      cmp_s1 <= comparator_out_i;
      cmp_s2 <= cmp_s1;
      cmp_s3 <= cmp_s2;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count <= tmr_pkg::COUNT_RESET;
      presc <= tmr_pkg::PRESC_RESET; // [R14]
      option <= tmr_pkg::OPTION_RESET;
      cmp_ctl <= tmr_pkg::CMP_RESET;
      inhibit <= 2'h0;
      rdata_o <= 8'h00;
      wdt_out <= 1'b0;
    end else if (clk_en_i) begin
      count <= next_count;
      presc <= next_presc;
      option <= next_option;
      cmp_ctl <= next_cmp_ctl;
      inhibit <= next_inhibit;
      rdata_o <= next_rdata;
      wdt_out <= next_wdt_out;
    end
  end

  assign watchdog_timeout_o = wdt_out;

  sequence s_count_write;
    clk_en_i && write_count;
  endsequence

  sequence s_held_two;
    (clk_en_i && !write_count) [*2];
  endsequence

  AST_INHIBIT_TWO: assert property (@(posedge ref_clk_i) // [R3]
    disable iff (!rst_b_i)
    s_count_write ##1 s_held_two |-> count == $past(wdata_i, 2))
    else $error("count moved during inhibit");

  AST_WRITE_CLEARS_PRESC: assert property (@(posedge ref_clk_i) // [R14]
    disable iff (!rst_b_i)
    clk_en_i && write_count && presc_to_timer |=> presc == 8'h00)
    else $error("prescaler not cleared by count write");

  AST_TIMER_EVERY_CYCLE: assert property (@(posedge ref_clk_i) // [R2]
    disable iff (!rst_b_i)
    clk_en_i && !write_count && inhibit == 2'h0 && !presc_to_timer
    && !option[tmr_pkg::OPT_SRC_BIT] |=> count == $past(count) + 8'h01)
    else $error("timer missed a cycle");

  AST_WDT_NO_TIMER: assert property (@(posedge ref_clk_i) // [R9]
    disable iff (!rst_b_i)
    !presc_to_timer |-> !presc_out)
    else $error("prescaler drove timer while assigned to watchdog");

  AST_TIMER_NO_WDT: assert property (@(posedge ref_clk_i) // [R10]
    disable iff (!rst_b_i)
    clk_en_i && presc_to_timer |=> !wdt_out)
    else $error("watchdog ticked while prescaler on timer");

  AST_RISE_EDGE: assert property (@(posedge ref_clk_i) // [R6]
    disable iff (!rst_b_i)
    src == SRC_PIN && !option[tmr_pkg::OPT_EDGE_BIT] && src_event
    |-> pin_s2 && !pin_s3)
    else $error("counted wrong pin edge");

  AST_CMP_IGNORES_OUTEN: assert property (@(posedge ref_clk_i) // [R8]
    disable iff (!rst_b_i)
    option[tmr_pkg::OPT_SRC_BIT] && !cmp_ctl[tmr_pkg::CMP_CSEL_BIT]
    |-> src == SRC_CMP)
    else $error("comparator mode lost");

  AST_WRAP: assert property (@(posedge ref_clk_i) // [R18]
    disable iff (!rst_b_i)
    clk_en_i && count == 8'hFF && tick && inhibit == 2'h0 && !write_count
    |=> count == 8'h00)
    else $error("count did not wrap");

  AST_INHIBIT_HOLD: assert property (@(posedge ref_clk_i) // [R3]
    disable iff (!rst_b_i)
    clk_en_i && !write_count && inhibit != 2'h0 |=> count == $past(count))
    else $error("count moved while inhibited");

  AST_FALL_EDGE: assert property (@(posedge ref_clk_i) // [R6]
    disable iff (!rst_b_i)
    src == SRC_PIN && option[tmr_pkg::OPT_EDGE_BIT] && src_event
    |-> !pin_s2 && pin_s3)
    else $error("counted rising edge in falling mode");

  AST_PIN_SYNC_ONLY: assert property (@(posedge ref_clk_i) // [R16]
    disable iff (!rst_b_i)
    src == SRC_PIN && src_event |-> pin_s2 != pin_s3)
    else $error("pin event without synchronised change");

  AST_NO_SOURCE_HOLD: assert property (@(posedge ref_clk_i) // [R4]
    disable iff (!rst_b_i)
    clk_en_i && !write_count && option[tmr_pkg::OPT_SRC_BIT]
    && cmp_ctl[tmr_pkg::CMP_CSEL_BIT] && !cmp_ctl[tmr_pkg::CMP_OUTEN_BIT]
    |=> count == $past(count))
    else $error("count moved with no source selected");

  AST_TIMER_SOURCE: assert property (@(posedge ref_clk_i) // [R1]
    disable iff (!rst_b_i)
    !option[tmr_pkg::OPT_SRC_BIT] |-> src == SRC_TIMER && src_event)
    else $error("timer mode lost its cycle source");

  AST_TICK_NEEDS_EVENT: assert property (@(posedge ref_clk_i) // [R18]
    disable iff (!rst_b_i)
    presc_to_timer && tick |-> src_event)
    else $error("prescaler ticked without a source event");

  AST_STATUS_HIDES_PRESC: assert property (@(posedge ref_clk_i) // [R11]
    disable iff (!rst_b_i)
    clk_en_i && rd_i && addr_i == tmr_pkg::ADDR_STATUS
    |=> rdata_o[7:3] == 5'h00)
    else $error("status read leaked upper bits");

  AST_RDATA_ONE_CYCLE: assert property (@(posedge ref_clk_i) // [R11]
    disable iff (!rst_b_i)
    clk_en_i && !rd_i |=> rdata_o == 8'h00)
    else $error("read data held past its cycle");

  AST_OPTION_WRITE: assert property (@(posedge ref_clk_i) // [R15]
    disable iff (!rst_b_i)
    clk_en_i && wr_i && addr_i == tmr_pkg::ADDR_OPTION
    |=> {2'h0, option} == ($past(wdata_i) & 8'h3F))
    else $error("option write not stored");
endmodule

/* sim/count_source_model.sv */
// far-side model: drives the count pin and the comparator output
// assumes the bench calls toggle between its own bus cycles
`timescale 1ns/1ps
module count_source_model (
  input wire logic ref_clk_i,
  output logic pin_o,
  output logic cmp_o
);
  initial begin
    pin_o = 1'b0;
    cmp_o = 1'b0;
  end
  // four cycles a level, well over what the three-flop sampler needs
  task automatic toggle(input int n, input bit use_cmp);
    repeat (n) begin
      @(posedge ref_clk_i);
      if (use_cmp) cmp_o <= ~cmp_o;
      else pin_o <= ~pin_o;
      repeat (3) @(posedge ref_clk_i);
    end
  endtask
endmodule

/* sim/timer_counter_tb.sv */
// self-checking bench for the timer/counter
// assumes clock enable high and watchdog clear idle throughout
`timescale 1ns/1ps
module timer_counter_tb;
  logic ref_clk_i, rst_b_i, wr_i, rd_i, wd_tick, pin, cmp, wd_out;
  logic [1:0] addr_i;
  logic [7:0] wdata_i, rdata_o, last;
  int err_total, check_count, cycles, wd_n;
  timer_counter u_timer_counter (.ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i), .clk_en_i(1'b1), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .external_count_pin_i(pin), .comparator_out_i(cmp),
    .watchdog_tick_i(wd_tick), .watchdog_clear_i(1'b0),
    .watchdog_timeout_o(wd_out));
  count_source_model u_count_source_model (.ref_clk_i(ref_clk_i),
    .pin_o(pin), .cmp_o(cmp));
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cycles++;
    if (wd_out === 1'b1) wd_n++;
    if (cycles == 10000) begin
      err_total++;
      final_report();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one bus cycle; last holds the answer to the read of the call before
  task automatic cyc(input logic w, input logic r, input logic [1:0] a,
                     input logic [7:0] d);
    @(posedge ref_clk_i);
    wr_i <= w;
    rd_i <= r;
    addr_i <= a;
    wdata_i <= d;
    #1 last = rdata_o;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    cyc(1'b0, 1'b1, a, 8'h00);
    cyc(1'b0, 1'b0, a, 8'h00);
    check(last, exp);
  endtask
  task automatic test_inhibit();
    logic [7:0] exp [5] = '{8'hFE, 8'hFE, 8'hFE, 8'hFF, 8'h00};
    cyc(1'b1, 1'b0, tmr_pkg::ADDR_OPTION, 8'h08);
    cyc(1'b1, 1'b0, tmr_pkg::ADDR_COUNT, 8'hFE);
    for (int i = 0; i < 6; i++) begin
      cyc(1'b0, i < 5, tmr_pkg::ADDR_COUNT, 8'h00);
      if (i > 0) check(last, exp[i-1]);
    end
  endtask
  // count gained over exactly four prescaler periods is phase-free
  task automatic test_prescale();
    logic [7:0] first;
    for (int n = 0; n < 8; n++) begin
      cyc(1'b1, 1'b0, tmr_pkg::ADDR_OPTION, {5'h00, n[2:0]});
      cyc(1'b1, 1'b0, tmr_pkg::ADDR_COUNT, 8'h00);
      repeat (4) cyc(1'b0, 1'b0, 2'h0, 8'h00);
      // fast ratios already ticked once after the inhibit ended
      rd(tmr_pkg::ADDR_COUNT, (n < 2) ? 8'h01 : 8'h00);
      first = last;
      repeat ((2 << n) * 4 - 2) cyc(1'b0, 1'b0, 2'h0, 8'h00);
      rd(tmr_pkg::ADDR_COUNT, first + 8'h04);
    end
    rd(tmr_pkg::ADDR_STATUS, 8'h01);
  endtask
  task automatic test_watchdog();
    wd_tick <= 1'b1;
    wd_n = 0;
    repeat (64) cyc(1'b0, 1'b0, 2'h0, 8'h00);
    check(8'(wd_n), 8'h00);
    cyc(1'b1, 1'b0, tmr_pkg::ADDR_OPTION, 8'h08);
    cyc(1'b0, 1'b0, 2'h0, 8'h00);
    wd_n = 0;
    repeat (64) cyc(1'b0, 1'b0, 2'h0, 8'h00);
    check({7'h00, wd_n >= 31 && wd_n <= 33}, 8'h01);
    wd_tick <= 1'b0;
  endtask
  // falling then rising edges; seven toggles give 4 of one edge, 3 other
  task automatic test_pin();
    cyc(1'b1, 1'b0, tmr_pkg::ADDR_CMP, 8'h48);
    for (int e = 0; e < 2; e++) begin
      cyc(1'b1, 1'b0, tmr_pkg::ADDR_OPTION, e ? 8'h28 : 8'h38);
      cyc(1'b1, 1'b0, tmr_pkg::ADDR_COUNT, 8'h00);
      cyc(1'b0, 1'b0, 2'h0, 8'h00);
      u_count_source_model.toggle(7, 1'b0);
      repeat (4) cyc(1'b0, 1'b0, 2'h0, 8'h00);
      rd(tmr_pkg::ADDR_COUNT, 8'h03);
    end
  endtask
  task automatic test_cmp();
    for (int k = 0; k < 2; k++) begin
      cyc(1'b1, 1'b0, tmr_pkg::ADDR_CMP, k ? 8'h40 : 8'h00);
      cyc(1'b1, 1'b0, tmr_pkg::ADDR_COUNT, 8'h00);
      cyc(1'b0, 1'b0, 2'h0, 8'h00);
      u_count_source_model.toggle(6, 1'b0);
      u_count_source_model.toggle(8, 1'b1);
      repeat (4) cyc(1'b0, 1'b0, 2'h0, 8'h00);
      rd(tmr_pkg::ADDR_COUNT, 8'h04);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    rst_b_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    wd_tick = 1'b0;
    addr_i = 2'h0;
    wdata_i = 8'h00;
    repeat (6) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    rd(tmr_pkg::ADDR_COUNT, 8'h00);
    test_inhibit();
    test_prescale();
    test_watchdog();
    test_pin();
    test_cmp();
    final_report();
  end
endmodule
